// [logic/tecu_pkg.sv]
/*
 * Constants and types shared by the timer/event capture unit.
 * Assumes a single 40 MHz peripheral clock drives every user of it.
 */
package tecu_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [15:0] TECU_DIR_ADDR = 16'hff22;
    localparam logic [15:0] TECU_ANA_ADDR = 16'hff84;
    localparam logic [7:0] TECU_DIR_RESET = 8'hff;
    localparam logic [7:0] TECU_ANA_RESET = 8'h00;
    localparam logic [3:0] TECU_DIR_FIXED = 4'hf;
    localparam logic [3:0] TECU_ANA_FIXED = 4'h0;
    localparam logic [7:0] TECU_UNMAPPED = 8'h00;
    localparam int TECU_PIN_BITS = 4;

    // ----------------------------------------
    // Counter and prescaler
    // ----------------------------------------
    localparam int TECU_CNT_W = 16;
    localparam logic [15:0] TECU_CNT_MAX = 16'hffff;
    localparam logic [15:0] TECU_CNT_ZERO = 16'h0000;
    localparam logic [15:0] TECU_CNT_ONE = 16'h0001;
    localparam logic [7:0] TECU_DIV4_MASK = 8'h03;
    localparam logic [7:0] TECU_DIV256_MASK = 8'hff;

    // ----------------------------------------
    // Field encodings
    // ----------------------------------------
    localparam logic [1:0] TECU_CLK_FXP = 2'h0;
    localparam logic [1:0] TECU_CLK_DIV4 = 2'h1;
    localparam logic [1:0] TECU_CLK_DIV256 = 2'h2;
    localparam logic [1:0] TECU_CLK_EVENT = 2'h3;
    localparam logic [1:0] TECU_EDGE_FALL = 2'h0;
    localparam logic [1:0] TECU_EDGE_RISE = 2'h1;
    localparam logic [1:0] TECU_EDGE_BOTH = 2'h3;

    typedef enum logic [1:0] {
        TECU_MODE_STOP = 2'b00,
        TECU_MODE_FREE = 2'b01,
        TECU_MODE_CLEAR = 2'b10
    } tecu_mode_t;
endpackage

// [logic/tecu_timer.sv]
/*
 * 16-bit timer/event counter with compare-clear, event counting,
 * capture into a second register, and the port-2 pin routing registers.
 * Assumes all inputs are synchronous to i_core_clk; timer controls are
 * held stable by software while the timer runs.
 */
// How it works
// - reset loads direction FFH, analog 00H
// - direction bit 0 output, 1 input
// - analog bit 0 port, 1 converter
// - compare match clears counter, raises compare interrupt
// - interval is compare value plus one
// - clear mode overflows only at FFFFH compare
// - lowered compare counts through overflow; restart
// - clock field selects counter count clock
// - event mode counts valid edges, clears on match
// - edge field picks rising, falling or both
// - event edge needs two equal fxp samples
// - counting starts after first filtered edge
// - capture samples on prescaler tick (fxp in event mode), twice
// - valid capture edge copies counter, raises interrupt
// - edge codes 00 fall, 01 rise, 11 both
// - clock codes fxp, /4, /256, event edge
`timescale 1ns/1ps
`default_nettype none
module tecu_timer (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire tecu_pkg::tecu_mode_t i_timer_mode,
    input wire logic [1:0] i_clock_sel,
    input wire logic [1:0] i_edge_sel_a,
    input wire logic [15:0] i_compare0,
    input wire logic i_overflow_clear,
    input wire logic i_event_capture_input_a,
    output logic [7:0] o_rdata,
    output logic [7:0] o_port2_direction,
    output logic [7:0] o_port2_analog_select,
    output logic [3:0] o_pin_output_enable,
    output logic [15:0] o_main_counter,
    output logic [15:0] o_compare_capture_reg1,
    output logic o_compare0_interrupt,
    output logic o_capture1_interrupt,
    output logic o_overflow_flag
);
    import tecu_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic edge_ok(input logic [1:0] sel,
                                     input logic rise,
                                     input logic fall);
        case (sel)
            TECU_EDGE_FALL: edge_ok = fall;
            TECU_EDGE_RISE: edge_ok = rise;
            TECU_EDGE_BOTH: edge_ok = rise | fall;
            default: edge_ok = 1'b0; // Prohibited code counts nothing
        endcase
    endfunction

    // ----------------------------------------
    // Port-2 registers
    // ----------------------------------------
    logic [3:0] dir_reg, dir_next;
    logic [3:0] ana_reg, ana_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [3:0] oe_reg, oe_next;
    logic [7:0] dir_view, ana_view;

    always_comb begin
        dir_view = {TECU_DIR_FIXED, dir_reg};
        ana_view = {TECU_ANA_FIXED, ana_reg};
        dir_next = dir_reg;
        ana_next = ana_reg;
        if (i_wr_en && i_addr == TECU_DIR_ADDR) begin
            dir_next = i_wdata[TECU_PIN_BITS-1:0];
        end
        if (i_wr_en && i_addr == TECU_ANA_ADDR) begin
            ana_next = i_wdata[TECU_PIN_BITS-1:0];
        end
        rdata_next = rdata_reg;
        if (i_rd_en) begin
            case (i_addr)
                TECU_DIR_ADDR: rdata_next = dir_view;
                TECU_ANA_ADDR: rdata_next = ana_view;
                default: rdata_next = TECU_UNMAPPED;
            endcase
        end
        // Buffer on only for an output-mode pin not given to the converter
        oe_next = ~(dir_next | ana_next);
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dir_reg <= TECU_DIR_RESET[3:0];
            ana_reg <= TECU_ANA_RESET[3:0];
            rdata_reg <= TECU_UNMAPPED;
            oe_reg <= 4'h0;
        end else begin
            dir_reg <= dir_next;
            ana_reg <= ana_next;
            rdata_reg <= rdata_next;
            oe_reg <= oe_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_port2_direction = {TECU_DIR_FIXED, dir_reg};
    assign o_port2_analog_select = {TECU_ANA_FIXED, ana_reg};
    assign o_pin_output_enable = oe_reg;

    // ----------------------------------------
    // Prescaler and input filters
    // ----------------------------------------
    logic [7:0] presc_reg, presc_next;
    logic evt_s0_reg, evt_s1_reg, evt_filt_reg;
    logic evt_s0_next, evt_s1_next, evt_filt_next;
    logic cap_s0_reg, cap_s1_reg, cap_filt_reg;
    logic cap_s0_next, cap_s1_next, cap_filt_next;
    logic div_tick, sample_en, evt_edge, cap_edge, count_tick, running;

    always_comb begin
        presc_next = presc_reg + 8'h01;
        // Count clock choice, code order fxp, /4, /256, event
        case (i_clock_sel)
            TECU_CLK_FXP: div_tick = 1'b1;
            TECU_CLK_DIV4: div_tick = (presc_reg & TECU_DIV4_MASK) ==
                                      TECU_DIV4_MASK;
            TECU_CLK_DIV256: div_tick = presc_reg == TECU_DIV256_MASK;
            default: div_tick = 1'b1;
        endcase
        // Event filter always samples at fxp
        evt_s0_next = i_event_capture_input_a;
        evt_s1_next = evt_s0_reg;
        evt_filt_next = evt_filt_reg;
        if (evt_s0_reg == evt_s1_reg) begin
            evt_filt_next = evt_s1_reg;
        end
        // Capture filter samples on the prescaler tick, every fxp in event mode
        sample_en = div_tick;
        cap_s0_next = cap_s0_reg;
        cap_s1_next = cap_s1_reg;
        cap_filt_next = cap_filt_reg;
        if (sample_en) begin
            cap_s0_next = i_event_capture_input_a;
            cap_s1_next = cap_s0_reg;
            if (cap_s0_reg == cap_s1_reg) begin
                cap_filt_next = cap_s1_reg;
            end
        end
        evt_edge = edge_ok(i_edge_sel_a, evt_filt_next & ~evt_filt_reg,
                           ~evt_filt_next & evt_filt_reg);
        cap_edge = edge_ok(i_edge_sel_a, cap_filt_next & ~cap_filt_reg,
                           ~cap_filt_next & cap_filt_reg);
        running = i_timer_mode != TECU_MODE_STOP;
        // Event clock waits for a filtered edge, so no count at start
        count_tick = running && ((i_clock_sel == TECU_CLK_EVENT) ?
                     evt_edge : div_tick);
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            presc_reg <= 8'h00;
            evt_s0_reg <= 1'b0;
            evt_s1_reg <= 1'b0;
            evt_filt_reg <= 1'b0;
            cap_s0_reg <= 1'b0;
            cap_s1_reg <= 1'b0;
            cap_filt_reg <= 1'b0;
        end else begin
            presc_reg <= presc_next;
            evt_s0_reg <= evt_s0_next;
            evt_s1_reg <= evt_s1_next;
            evt_filt_reg <= evt_filt_next;
            cap_s0_reg <= cap_s0_next;
            cap_s1_reg <= cap_s1_next;
            cap_filt_reg <= cap_filt_next;
        end
    end

    // ----------------------------------------
    // Counter, capture and flags
    // ----------------------------------------
    logic [15:0] cnt_reg, cnt_next, cap1_reg, cap1_next;
    logic irq0_reg, irq0_next, irq1_reg, irq1_next, ovf_reg, ovf_next;
    logic wrap, match;

    always_comb begin
        cnt_next = cnt_reg;
        cap1_next = cap1_reg;
        irq0_next = 1'b0;
        irq1_next = 1'b0;
        wrap = count_tick && cnt_reg == TECU_CNT_MAX;
        match = count_tick && i_timer_mode == TECU_MODE_CLEAR &&
                cnt_reg == i_compare0;
        if (!running) begin
            cnt_next = TECU_CNT_ZERO;
        end else if (match) begin
            cnt_next = TECU_CNT_ZERO;
            irq0_next = 1'b1;
        end else if (count_tick) begin
            // Past a lowered compare it runs on to the wrap
            cnt_next = cnt_reg + TECU_CNT_ONE;
        end
        // Only a compare of FFFFH lets clear mode reach the wrap normally
        ovf_next = ovf_reg;
        if (i_overflow_clear) begin
            ovf_next = 1'b0;
        end
        if (wrap) begin
            ovf_next = 1'b1;
        end
        if (running && cap_edge) begin
            cap1_next = cnt_reg;
            irq1_next = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= TECU_CNT_ZERO;
            cap1_reg <= TECU_CNT_ZERO;
            irq0_reg <= 1'b0;
            irq1_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            cap1_reg <= cap1_next;
            irq0_reg <= irq0_next;
            irq1_reg <= irq1_next;
            ovf_reg <= ovf_next;
        end
    end

    assign o_main_counter = cnt_reg;
    assign o_compare_capture_reg1 = cap1_reg;
    assign o_compare0_interrupt = irq0_reg;
    assign o_capture1_interrupt = irq1_reg;
    assign o_overflow_flag = ovf_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    dir_reset_a: assert property (
        !$past(i_rst_n) |-> o_port2_direction == TECU_DIR_RESET &&
        o_port2_analog_select == TECU_ANA_RESET)
        else $error("port2 reset values wrong");
    dir_fixed_a: assert property (
        o_port2_direction[7:4] == 4'hf)
        else $error("direction upper bits not one");
    oe_mode_a: assert property (
        i_wr_en && i_addr == TECU_DIR_ADDR |=>
        o_port2_direction[0] == $past(i_wdata[0]) &&
        o_pin_output_enable[0] == ~(o_port2_direction[0] |
                                    o_port2_analog_select[0]))
        else $error("direction bit or buffer wrong");
    ana_fixed_a: assert property (
        o_port2_analog_select[7:4] == 4'h0)
        else $error("analog upper bits not zero");
    match_clear_a: assert property (
        match |=> o_main_counter == 16'h0000 && o_compare0_interrupt)
        else $error("match did not clear and interrupt");
    count_step_a: assert property (
        count_tick && !match && cnt_reg != 16'hffff |=>
        o_main_counter == $past(cnt_reg) + 16'h0001)
        else $error("counter did not step by one");
    ovf_source_a: assert property (
        $rose(o_overflow_flag) |-> $past(cnt_reg) == 16'hffff)
        else $error("overflow without wrap");
    event_hold_a: assert property (
        running && i_clock_sel == TECU_CLK_EVENT && !evt_edge |=>
        $stable(o_main_counter))
        else $error("event counter moved without edge");
    evt_filter_a: assert property (
        $changed(evt_filt_reg) |-> $past(i_event_capture_input_a, 2) ==
        evt_filt_reg && $past(i_event_capture_input_a, 3) == evt_filt_reg)
        else $error("event filter passed single sample");
    capture_a: assert property (
        running && cap_edge |=> o_compare_capture_reg1 == $past(cnt_reg)
        && o_capture1_interrupt)
        else $error("capture did not copy counter");
    wrap_a: assert property (
        wrap && !match |=> o_main_counter == 16'h0000 && o_overflow_flag)
        else $error("wrap did not set overflow");

    interval_c: cover property (o_compare0_interrupt ##[1:40]
                                o_compare0_interrupt);
    capture_c: cover property (o_capture1_interrupt);
    overflow_c: cover property ($rose(o_overflow_flag));
    event_c: cover property (i_clock_sel == TECU_CLK_EVENT && evt_edge);
endmodule
`default_nettype wire

// [test/tecu_pulse_src.sv]
/* Event and capture pulse source model for the timer input.
   Assumes the bench calls pulse from its own clock domain. */
`timescale 1ns/1ps
`default_nettype none
module tecu_pulse_src (
    input wire logic i_clk,
    output logic o_level
);
    initial o_level = 1'b0;
    // Widths stay above one counter cycle, else unresolvable
    task automatic pulse(input int hi, input int lo);
        @(posedge i_clk);
        o_level <= 1'b1;
        repeat (hi) @(posedge i_clk);
        o_level <= 1'b0;
        repeat (lo) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// [test/timer_event_capture_unit_bench.sv]
/* Self-checking bench for the timer/event capture unit.
   Assumes tecu_pkg and the pulse source model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module timer_event_capture_unit_bench;
    import tecu_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ovc = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00;
    tecu_mode_t mode = TECU_MODE_STOP;
    logic [1:0] sel = 2'h0;
    logic [1:0] edg = 2'h1;
    logic [15:0] cmp = 16'h0001;
    logic ev, irq0, irq1, ovf;
    logic [7:0] rdata, dir, ana;
    logic [3:0] oe;
    logic [15:0] cnt, cap, cap_last;
    logic rd_seen = 1'b0;
    logic cap_have = 1'b0;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    int t_irq[$];
    logic [15:0] rd_q[$];
    logic [15:0] cap_q[$];
    int dv[3] = '{1, 4, 256};
    // Code 10 is prohibited, so it must count nothing
    logic [1:0] ec[4] = '{TECU_EDGE_FALL, TECU_EDGE_RISE, TECU_EDGE_BOTH,
                          2'h2};
    int xe[4] = '{2, 2, 4, 0};
    tecu_timer i_tecu_timer (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr), .i_wdata(wd),
        .i_timer_mode(mode), .i_clock_sel(sel), .i_edge_sel_a(edg),
        .i_compare0(cmp), .i_overflow_clear(ovc),
        .i_event_capture_input_a(ev), .o_rdata(rdata),
        .o_port2_direction(dir), .o_port2_analog_select(ana),
        .o_pin_output_enable(oe), .o_main_counter(cnt),
        .o_compare_capture_reg1(cap), .o_compare0_interrupt(irq0),
        .o_capture1_interrupt(irq1), .o_overflow_flag(ovf));
    tecu_pulse_src i_tecu_pulse_src (.i_clk(i_core_clk), .o_level(ev));

    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    // ----------------------------------------
    // Result watchers
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] e,
                         input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Ceiling covers one full 16-bit count plus the short tests
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        rd_seen <= rd;
        if (cyc == 90000) begin
            fails++;
            tally_and_finish();
        end
    end
    always @(negedge i_core_clk) begin
        if (rd_seen) begin
            check("rdata", rd_q.pop_front(), {8'h00, rdata});
        end
        if (irq0) begin
            t_irq.push_back(cyc);
        end
        // Captures outside the capture test carry no note
        if (irq1 && cap_q.size() > 0) begin
            if (cap_have) begin
                check("capture", cap_q.pop_front(), cap - cap_last);
            end
            cap_last = cap;
            cap_have = 1'b1;
        end
    end
    // ----------------------------------------
    // Drivers and tests
    // ----------------------------------------
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] d, input logic [7:0] e);
        @(posedge i_core_clk);
        if (!w) begin
            rd_q.push_back({8'h00, e});
        end
        wr <= w;
        rd <= !w;
        addr <= a;
        wd <= d;
        @(posedge i_core_clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // Stop first so the compare is never rewritten while counting
    task automatic start(input tecu_mode_t m, input logic [1:0] s,
                         input logic [1:0] e, input logic [15:0] c);
        @(posedge i_core_clk);
        mode <= TECU_MODE_STOP;
        @(posedge i_core_clk);
        cmp <= c;
        edg <= e;
        sel <= s;
        @(posedge i_core_clk);
        mode <= m;
        t_irq.delete();
    endtask

    initial begin
        int n;
        logic [7:0] d, a;
        void'($urandom(25));
        repeat (10) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(negedge i_core_clk);
        check("dir", 16'h00ff, {8'h00, dir});
        check("ana", 16'h0000, {8'h00, ana});
        check("oe", 16'h0000, {12'h000, oe});
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            a = 8'($urandom);
            bus(1'b1, TECU_DIR_ADDR, d, 8'h00);
            bus(1'b1, TECU_ANA_ADDR, a, 8'h00);
            bus(1'b0, TECU_DIR_ADDR, 8'h00, {4'hf, d[3:0]});
            bus(1'b0, TECU_ANA_ADDR, 8'h00, {4'h0, a[3:0]});
            @(negedge i_core_clk);
            check("oe", {12'h000, ~(d[3:0] | a[3:0])}, {12'h000, oe});
        end
        bus(1'b0, 16'hff23, 8'h00, 8'h00);
        bus(1'b1, TECU_DIR_ADDR, 8'hff, 8'h00);
        bus(1'b1, TECU_ANA_ADDR, 8'h00, 8'h00);
        $display("done registers");
        for (int s = 0; s < 3; s++) begin
            n = 2 + int'($urandom % 8);
            start(TECU_MODE_CLEAR, 2'(s), TECU_EDGE_RISE, 16'(n));
            while (t_irq.size() < 3) @(negedge i_core_clk);
            check("interval", 16'(dv[s] * (n + 1)), 16'(t_irq[2] - t_irq[1]));
            check("ovf", 16'h0000, {15'h0000, ovf});
        end
        $display("done interval");
        for (int k = 0; k < 4; k++) begin
            start(TECU_MODE_CLEAR, TECU_CLK_EVENT, ec[k], 16'h00ff);
            i_tecu_pulse_src.pulse(1, 4);
            check("glitch", 16'h0000, cnt);
            i_tecu_pulse_src.pulse(3, 3);
            i_tecu_pulse_src.pulse(3, 3);
            repeat (2) @(negedge i_core_clk);
            check("events", 16'(xe[k]), cnt);
        end
        start(TECU_MODE_CLEAR, TECU_CLK_EVENT, TECU_EDGE_RISE, 16'h0002);
        repeat (3) i_tecu_pulse_src.pulse(3, 3);
        @(negedge i_core_clk);
        check("match", 16'h0000, cnt);
        check("irq0", 16'h0001, 16'(t_irq.size()));
        $display("done events");
        start(TECU_MODE_FREE, TECU_CLK_FXP, TECU_EDGE_BOTH, 16'hffff);
        for (int k = 0; k < 3; k++) begin
            n = 3 + int'($urandom % 30);
            cap_have = 1'b0;
            cap_q.push_back(16'(n));
            i_tecu_pulse_src.pulse(n, 6);
        end
        check("caps left", 16'h0000, 16'(cap_q.size()));
        $display("done capture");
        start(TECU_MODE_CLEAR, TECU_CLK_FXP, TECU_EDGE_RISE, 16'hffff);
        while (t_irq.size() < 1) @(negedge i_core_clk);
        repeat (2) @(negedge i_core_clk);
        check("ovf full", 16'h0001, {15'h0000, ovf});
        @(posedge i_core_clk);
        ovc <= 1'b1;
        @(posedge i_core_clk);
        ovc <= 1'b0;
        @(negedge i_core_clk);
        check("ovf clear", 16'h0000, {15'h0000, ovf});
        $display("done overflow");
        tally_and_finish();
    end
endmodule
`default_nettype wire
